/* File: logic/sdmt_params.svh */
/*
  constants for the step/direction microstep translator: widths, table sizes,
  resolution codes and the sixteen-entry default phase profile.
  assumes it is included by bare name from files that need the figures.
*/
`ifndef SDMT_PARAMS_SVH
`define SDMT_PARAMS_SVH

`define SDMT_ANGLE_W       6
`define SDMT_ANGLE_RESET   6'h00
`define SDMT_CFG_RES_RESET 2'h0
`define SDMT_FULL_OFFSET   6'h08
`define SDMT_STEP_FULL     6'h10
`define SDMT_STEP_HALF     6'h08
`define SDMT_STEP_QUARTER  6'h04
`define SDMT_STEP_SIXTEEN  6'h01
`define SDMT_MAG_W         6
`define SDMT_MAG_FULL      6'h3f
// default sine-like profile, entries 0..15 (rising magnitude)
`define SDMT_PROFILE_DEFAULT {6'h3f, 6'h3f, 6'h3e, 6'h3c, 6'h3a, 6'h37, 6'h34, 6'h30, \
                              6'h2c, 6'h27, 6'h22, 6'h1d, 6'h17, 6'h11, 6'h0c, 6'h06}

`endif

/* File: logic/sdmt_pkg.sv */
/*
  types shared by both ends of the translator link.
  assumes sdmt_params.svh is available for the numeric constants.
*/
package sdmt_pkg;
  typedef enum logic [1:0] {
    SDMT_RES_FULL,
    SDMT_RES_HALF,
    SDMT_RES_QUARTER,
    SDMT_RES_SIXTEENTH
  } sdmt_res_e;

  typedef logic [5:0] sdmt_angle_t;
endpackage

/* File: logic/sdmt_link_if.sv */
/*
  link between the controller and the translator: step, direction, resolution
  pins and the serial step-change strobe with its signed amount.
  assumes both ends run on the same core clock; pins are synchronised inside.
*/
`timescale 1ns/1ps
interface sdmt_link_if;
  logic       step;              // rising edge commands one move
  logic       dir_fwd;           // 1 = forward
  logic       res_select_lo;
  logic       res_select_hi;
  logic       serial_strobe_n;   // rising edge applies serial_change
  logic [5:0] serial_change;     // two's complement step change

  modport ctrl (
    output step, dir_fwd, res_select_lo, res_select_hi, serial_strobe_n, serial_change
  );
  modport dev (
    input step, dir_fwd, res_select_lo, res_select_hi, serial_strobe_n, serial_change
  );
endinterface

/* File: logic/sdmt_translator.sv */
/*
  device end: keeps the step angle number, moves it on step edges at the
  selected resolution or by the serial change, and looks up both phase codes.
  assumes link pins may come from another domain, so all pass two flip-flops.
*/
`timescale 1ns/1ps
`include "sdmt_params.svh"
module sdmt_translator
  import sdmt_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  sdmt_link_if.dev        link,
  input  wire logic [1:0] i_cfg_res,      // configuration select bits {hi,lo}
  input  wire logic       i_cfg_res_we,   // load i_cfg_res
  output logic [5:0]      o_angle,
  output logic [5:0]      o_mag_a,
  output logic            o_neg_a,
  output logic [5:0]      o_mag_b,
  output logic            o_neg_b,
  output logic [1:0]      o_res_eff
);

  // =====================================================================
  // helpers
  // =====================================================================
  localparam logic [95:0] PROFILE = `SDMT_PROFILE_DEFAULT;

  // sixteen profile values, index 0 is the smallest nonzero magnitude
  function automatic logic [5:0] prof(input logic [3:0] k);
    prof = PROFILE[6*k +: 6];
  endfunction

  // magnitude of a sine over one quarter: 0 at q=0, full at q=16
  function automatic logic [5:0] quarter_mag(input logic [4:0] q);
    if (q == 5'h00) begin
      quarter_mag = 6'h00;
    end else begin
      quarter_mag = prof(4'(q - 5'h01));
    end
  endfunction

  // next allowed position in the commanded direction
  function automatic logic [5:0] next_angle(input logic [5:0] a, input logic fwd,
                                            input logic [1:0] res);
    logic [5:0] sp;
    logic [5:0] off;
    logic [5:0] rel;
    logic [5:0] base;
    sp  = `SDMT_STEP_SIXTEEN;
    off = 6'h00;
    case (sdmt_res_e'(res))
      SDMT_RES_FULL: begin
        sp  = `SDMT_STEP_FULL;
        off = `SDMT_FULL_OFFSET;
      end
      SDMT_RES_HALF:    sp = `SDMT_STEP_HALF;
      SDMT_RES_QUARTER: sp = `SDMT_STEP_QUARTER;
      default:          sp = `SDMT_STEP_SIXTEEN;
    endcase
    rel  = a - off;
    base = rel & ~(sp - 6'h01);
    // forward: next grid point above; reverse: next grid point below
    if (fwd) begin
      next_angle = base + sp + off;
    end else if (rel != base) begin
      next_angle = base + off;
    end else begin
      next_angle = base - sp + off;
    end
  endfunction

  // =====================================================================
  // pin synchronisers and edge detect
  // =====================================================================
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic [10:0] sync_next;
  logic        step_d_reg;
  logic        step_d_next;
  logic        strb_d_reg;
  logic        strb_d_next;

  always_comb begin
    sync_next   = {link.step, link.dir_fwd, link.res_select_hi, link.res_select_lo,
                   link.serial_strobe_n, link.serial_change};
    step_d_next = sync2_reg[10];
    strb_d_next = sync2_reg[6];
  end

  // two stages; only the second is looked at
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg  <= 11'h040;
      sync2_reg  <= 11'h040;
      step_d_reg <= 1'b0;
      strb_d_reg <= 1'b1;
    end else begin
      sync1_reg  <= sync_next;
      sync2_reg  <= sync1_reg;
      step_d_reg <= step_d_next;
      strb_d_reg <= strb_d_next;
    end
  end

  wire       step_rise = sync2_reg[10] & ~step_d_reg;
  wire       dir_fwd   = sync2_reg[9];
  wire [1:0] pin_res   = sync2_reg[8:7];
  wire       strb_rise = sync2_reg[6] & ~strb_d_reg;
  wire [5:0] change    = sync2_reg[5:0];

  // =====================================================================
  // configuration bits and angle state
  // =====================================================================
  logic [1:0] cfg_res_reg;
  logic [1:0] cfg_res_next;
  logic [5:0] angle_reg;
  logic [5:0] angle_next;
  logic [1:0] res_eff;

  always_comb begin
    cfg_res_next = i_cfg_res_we ? i_cfg_res : cfg_res_reg;
    res_eff      = pin_res | cfg_res_reg;
    angle_next   = angle_reg;
    // the resolution is read fresh at every edge, so a change applies at the next one
    if (step_rise) begin
      angle_next = next_angle(angle_reg, dir_fwd, res_eff);
    end else if (strb_rise) begin
      angle_next = angle_reg + change;
    end
  end

  // step edge wins a same-cycle clash; the controller is expected to space them
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_res_reg <= `SDMT_CFG_RES_RESET;
      angle_reg   <= `SDMT_ANGLE_RESET;
    end else begin
      cfg_res_reg <= cfg_res_next;
      angle_reg   <= angle_next;
    end
  end

  // =====================================================================
  // phase table lookup
  // =====================================================================
  logic [5:0] mag_a_next;
  logic [5:0] mag_b_next;
  logic       neg_a_next;
  logic       neg_b_next;
  logic [5:0] mag_a_reg;
  logic [5:0] mag_b_reg;
  logic       neg_a_reg;
  logic       neg_b_reg;
  logic [3:0] pos;
  logic [1:0] quad;

  // angle 0: B full positive, A zero; each count is 5.625 degrees
  always_comb begin
    quad = angle_next[5:4];
    pos  = angle_next[3:0];
    mag_a_next = quarter_mag(quad[0] ? 5'(5'h10 - {1'b0, pos}) : {1'b0, pos});
    mag_b_next = quarter_mag(quad[0] ? {1'b0, pos} : 5'(5'h10 - {1'b0, pos}));
    neg_a_next = quad[1] & (mag_a_next != 6'h00);
    neg_b_next = (quad == 2'h1 || quad == 2'h2) && (mag_b_next != 6'h00);
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mag_a_reg <= 6'h00;
      mag_b_reg <= `SDMT_MAG_FULL;
      neg_a_reg <= 1'b0;
      neg_b_reg <= 1'b0;
    end else begin
      mag_a_reg <= mag_a_next;
      mag_b_reg <= mag_b_next;
      neg_a_reg <= neg_a_next;
      neg_b_reg <= neg_b_next;
    end
  end

  assign o_angle   = angle_reg;
  assign o_mag_a   = mag_a_reg;
  assign o_neg_a   = neg_a_reg;
  assign o_mag_b   = mag_b_reg;
  assign o_neg_b   = neg_b_reg;
  assign o_res_eff = res_eff;

endmodule

/* File: logic/sdmt_controller.sv */
/*
  controller end: turns user move requests into step pulses or serial
  strobes, holding the pins steady around each edge.
  assumes the translator samples pins through two flip-flops on the same clock.
*/
`timescale 1ns/1ps
`include "sdmt_params.svh"
module sdmt_controller
  import sdmt_pkg::*;
#(
  parameter int HALF_W = 4   // each phase of a step or strobe is held HALF_W+1 cycles
)(
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  sdmt_link_if.ctrl       link,
  input  wire logic       i_step_req,    // one-cycle request for a step-input move
  input  wire logic       i_serial_req,  // one-cycle request for a serial move
  input  wire logic       i_dir_fwd,
  input  wire logic [1:0] i_res,         // pin resolution {hi,lo}
  input  wire logic [5:0] i_change,
  output logic            o_busy
);

  typedef enum logic [1:0] {SDMT_C_IDLE, SDMT_C_SETUP, SDMT_C_HIGH, SDMT_C_LOW} sdmt_cst_e;

  sdmt_cst_e  st_reg;
  sdmt_cst_e  st_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       ser_reg;
  logic       ser_next;
  logic       dir_reg;
  logic       dir_next;
  logic [1:0] res_reg;
  logic [1:0] res_next;
  logic [5:0] chg_reg;
  logic [5:0] chg_next;

  // =====================================================================
  // sequencer: setup, edge, recovery, so pins are stable across each edge
  // =====================================================================
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    ser_next = ser_reg;
    dir_next = dir_reg;
    res_next = res_reg;
    chg_next = chg_reg;
    case (st_reg)
      SDMT_C_IDLE: begin
        if (i_step_req || i_serial_req) begin
          ser_next = ~i_step_req & i_serial_req;
          dir_next = i_dir_fwd;
          res_next = i_res;
          chg_next = i_change;
          cnt_next = 8'(HALF_W);
          st_next  = SDMT_C_SETUP;
        end
      end
      SDMT_C_SETUP, SDMT_C_HIGH, SDMT_C_LOW: begin
        if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          cnt_next = 8'(HALF_W);
          st_next  = (st_reg == SDMT_C_SETUP) ? SDMT_C_HIGH :
                     (st_reg == SDMT_C_HIGH) ? SDMT_C_LOW : SDMT_C_IDLE;
        end
      end
      default: st_next = SDMT_C_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg  <= SDMT_C_IDLE;
      cnt_reg <= 8'h00;
      ser_reg <= 1'b0;
      dir_reg <= 1'b1;
      res_reg <= 2'h0;
      chg_reg <= 6'h00;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      ser_reg <= ser_next;
      dir_reg <= dir_next;
      res_reg <= res_next;
      chg_reg <= chg_next;
    end
  end

  // step high for a step move, strobe low then released for a serial move
  assign link.step            = (st_reg == SDMT_C_HIGH) & ~ser_reg;
  assign link.serial_strobe_n = ~((st_reg == SDMT_C_SETUP) & ser_reg);
  assign link.dir_fwd         = dir_reg;
  assign link.res_select_lo   = res_reg[0];
  assign link.res_select_hi   = res_reg[1];
  assign link.serial_change   = chg_reg;
  assign o_busy               = (st_reg != SDMT_C_IDLE);

endmodule

/* File: tb/sdmt_link_asserts.sv */
/*
  checker for the translator link: pin timing of the controller end and
  angle moves of the translator end.
  assumes it sits beside the link interface, all on one core clock.
*/
`timescale 1ns/1ps
module sdmt_link_asserts #(
  parameter int HALF_W = 4
)(
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic       step,
  input wire logic       dir_fwd,
  input wire logic       res_select_lo,
  input wire logic       res_select_hi,
  input wire logic       serial_strobe_n,
  input wire logic [5:0] o_angle,
  input wire logic [1:0] o_res_eff
);
  // ==========================================================================
  // link timing and angle moves
  // angle checks wait 4 edges: the move lands 3 edges after the pin rises
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  a_step_strobe_apart: assert property (step |-> serial_strobe_n)
    else $error("step and strobe active together");
  a_res_stable_step: assert property (step |-> $stable({res_select_hi, res_select_lo}))
    else $error("resolution pins moved while step high");
  a_dir_stable_step: assert property (step |-> $stable(dir_fwd))
    else $error("direction moved while step high");
  a_step_high_width: assert property ($rose(step) |-> ##HALF_W step ##1 !step)
    else $error("step high width wrong");
  a_strobe_low_width: assert property (
    $fell(serial_strobe_n) |-> ##HALF_W !serial_strobe_n ##1 serial_strobe_n)
    else $error("strobe low width wrong");
  a_sixteenth_fwd_one: assert property (
    $rose(step) && o_res_eff == 2'h3 && dir_fwd |-> ##4 o_angle == $past(o_angle, 4) + 6'h01)
    else $error("sixteenth forward move not plus one");
  a_sixteenth_back_one: assert property (
    $rose(step) && o_res_eff == 2'h3 && !dir_fwd |-> ##4 o_angle == $past(o_angle, 4) - 6'h01)
    else $error("sixteenth reverse move not minus one");
  a_full_grid_only: assert property ($rose(step) && o_res_eff == 2'h0 |-> ##4 o_angle[3:0] == 4'h8)
    else $error("full step left its grid");
  a_half_grid_only: assert property ($rose(step) && o_res_eff == 2'h1 |-> ##4 o_angle[2:0] == 3'h0)
    else $error("half step left its grid");
  a_quarter_grid_only: assert property ($rose(step) && o_res_eff == 2'h2 |-> ##4 o_angle[1:0] == 2'h0)
    else $error("quarter step left its grid");
endmodule

/* File: tb/test_step_dir_microstep_translator.sv */
/*
  self-checking bench: controller and translator joined by the link, moves
  driven from a table, angle, phase codes and resolution compared.
  assumes the package, interface and both design ends are compiled first.
*/
`timescale 1ns/1ps
module test_step_dir_microstep_translator;
  localparam int HALF_W = 2;
  logic       i_core_clk, i_resetn, i_step_req, i_serial_req, i_dir_fwd, o_busy;
  logic       i_cfg_res_we, o_neg_a, o_neg_b;
  logic [1:0] i_res, i_cfg_res, o_res_eff, cfg_now;
  logic [5:0] i_change, o_angle, o_mag_a, o_mag_b;
  int         bad_count, n_checks;
  // {serial, fwd, res, change, expected angle}; serial moves set up off-grid starts
  localparam logic [15:0] MOVES [17] = '{
    16'h303f, 16'h7000, 16'h8efb, 16'h603c, 16'h8ffb, 16'h5000,
    16'h8efb, 16'h4008, 16'h4018, 16'h4028, 16'h4038, 16'h4008,
    16'h0038, 16'h1030, 16'h202c, 16'h6030, 16'h8400};

  // ==========================================================================
  // design and checker
  sdmt_link_if u_sdmt_link_if ();
  sdmt_controller #(.HALF_W(HALF_W)) u_sdmt_controller (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .link(u_sdmt_link_if), .i_step_req(i_step_req),
    .i_serial_req(i_serial_req), .i_dir_fwd(i_dir_fwd), .i_res(i_res),
    .i_change(i_change), .o_busy(o_busy));
  sdmt_translator u_sdmt_translator (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .link(u_sdmt_link_if), .i_cfg_res(i_cfg_res), .i_cfg_res_we(i_cfg_res_we),
    .o_angle(o_angle), .o_mag_a(o_mag_a), .o_neg_a(o_neg_a), .o_mag_b(o_mag_b),
    .o_neg_b(o_neg_b), .o_res_eff(o_res_eff));
  sdmt_link_asserts #(.HALF_W(HALF_W)) u_sdmt_link_asserts (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .step(u_sdmt_link_if.step), .dir_fwd(u_sdmt_link_if.dir_fwd),
    .res_select_lo(u_sdmt_link_if.res_select_lo),
    .res_select_hi(u_sdmt_link_if.res_select_hi),
    .serial_strobe_n(u_sdmt_link_if.serial_strobe_n), .o_angle(o_angle),
    .o_res_eff(o_res_eff));

  // ==========================================================================
  // clock, tasks
  always #12.5 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0d want %0d", $time, got, exp);
    end
  endtask

  // one move through the controller; busy bounds the wait, no fixed guess
  task automatic move(input logic [15:0] e);
    int n;
    @(posedge i_core_clk);
    i_step_req   <= ~e[15];
    i_serial_req <= e[15];
    i_dir_fwd    <= e[14];
    i_res        <= e[13:12];
    i_change     <= e[11:6];
    @(posedge i_core_clk);
    i_step_req   <= 1'b0;
    i_serial_req <= 1'b0;
    #1;
    for (n = 0; n < 40 && o_busy !== 1'b0; n++) begin
      @(posedge i_core_clk);
      #1;
    end
    // a move that never ends is a failure in itself, not just a late angle
    if (o_busy !== 1'b0) begin
      bad_count++;
      $display("unexpected at %0t: move never finished", $time);
    end
    chk(o_angle, e[5:0]);
    if (!e[15]) chk({4'h0, o_res_eff}, {4'h0, e[13:12] | cfg_now});
  endtask

  task automatic cfg(input logic [1:0] v);
    @(posedge i_core_clk);
    i_cfg_res    <= v;
    i_cfg_res_we <= 1'b1;
    cfg_now      = v;
    @(posedge i_core_clk);
    i_cfg_res_we <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {i_core_clk, i_resetn, i_step_req, i_serial_req, i_dir_fwd, i_cfg_res_we} = 6'h00;
    {i_res, i_cfg_res, cfg_now, i_change} = 12'h000;
    bad_count = 0;
    n_checks  = 0;
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk(o_angle, 6'h00);
    chk(o_mag_a, 6'h00);
    chk(o_mag_b, 6'h3f);
    chk({4'h0, o_neg_a, o_neg_b}, 6'h00);
    chk({4'h0, o_res_eff}, 6'h00);
    foreach (MOVES[k]) move(MOVES[k]);
    chk(o_mag_b, 6'h3f);
    cfg(2'h3);
    move(16'h4001);
    cfg(2'h1);
    move(16'h6002);
    cfg(2'h0);
    move(16'h4008);
    // profile entry 7 on both phases at the 45 degree parking point
    chk(o_mag_a, 6'h2c);
    chk(o_mag_b, 6'h2c);
    // serial -32 lands in the third quadrant: both phases negative
    move(16'h8828);
    chk({4'h0, o_neg_a, o_neg_b}, 6'h03);
    // serial -12 to 28: A from entry 3 positive, B from entry 11 negative
    move(16'h8d1c);
    chk(o_mag_a, 6'h17);
    chk(o_mag_b, 6'h3a);
    chk({4'h0, o_neg_a, o_neg_b}, 6'h01);
    conclude();
  end

  // a hung handshake ends the run through the same verdict
  initial begin
    #100000;
    bad_count++;
    $display("unexpected at %0t: timeout", $time);
    conclude();
  end
endmodule
